/* File: logic/serial_port_pkg.sv */
/*
 Constants shared by both ends of the sensor serial port and its bench.
 Assumes a 250 MHz system clock on both ends; the link clock is made by the host end.
*/
package serial_port_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////
   localparam int CLK_KHZ = 250000;
   localparam int SCLK_SLOW_MAX_KHZ = 1000;
   localparam int SCLK_FAST_MAX_KHZ = 20000;
   // Least half period, rounded up so the clock never runs faster than allowed
   localparam int HALF_SLOW_CYC = (CLK_KHZ + 2 * SCLK_SLOW_MAX_KHZ - 1) / (2 * SCLK_SLOW_MAX_KHZ);
   localparam int HALF_FAST_CYC = (CLK_KHZ + 2 * SCLK_FAST_MAX_KHZ - 1) / (2 * SCLK_FAST_MAX_KHZ);

   ////////////////////////////////////////////////////////////////////////////////////////////
   localparam int IDX_W = 7;
   localparam int BYTE_W = 8;
   localparam int WORD_W = IDX_W + BYTE_W;
   localparam int FIFO_DEPTH = 16;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [3:0] ACK_CLOCK = 4'h9;
   localparam logic READ_FLAG = 1'h1;
   localparam logic [6:0] SENSOR_FIRST = 7'h10;
   localparam logic [6:0] SENSOR_LAST = 7'h1f;

   ////////////////////////////////////////////////////////////////////////////////////////////
   localparam logic [1:0] OP_XFER = 2'h0;
   localparam logic [1:0] OP_START = 2'h1;
   localparam logic [1:0] OP_STOP = 2'h2;
   localparam logic [1:0] OP_BIT = 2'h3;

endpackage : serial_port_pkg

/* File: logic/spi_link_if.sv */
/*
 Four-wire link between host end and device end.
 Assumes the device releases its data output by clearing sdo_oe; the level is resolved here.
*/
`timescale 1ns/1ns
interface spi_link_if;
   logic cs_n;
   logic sclk;
   logic sdi;
   logic sdo_o;
   logic sdo_oe;
   wire sdo;

   // No pull-up on this line: a released output shows the inverse, so a late sample stands out
   assign sdo = sdo_oe ? sdo_o : ~sdo_o;

   modport dev (input cs_n, input sclk, input sdi, output sdo_o, output sdo_oe);
   modport host (output cs_n, output sclk, output sdi, input sdo);
endinterface : spi_link_if

/* File: logic/word_fifo.sv */
/*
 Synchronous FIFO in flip-flops, valid and ready on both sides.
 Assumes one clock; depth is a power of two.
*/
`timescale 1ns/1ns
module word_fifo
   import serial_port_pkg::*;
#(
   parameter int W = WORD_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   input logic clk,
   input logic arst_n,
   input logic in_valid,
   output logic in_ready,
   input logic [W-1:0] in_data,
   output logic out_valid,
   input logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } fifo_s;

   fifo_s q_q;
   fifo_s q_d;

   ////////////////////////////////////////////////////////////////////////////////////////////
   assign in_ready = !((q_q.wp[AW] != q_q.rp[AW]) && (q_q.wp[AW-1:0] == q_q.rp[AW-1:0]));
   assign out_valid = (q_q.wp != q_q.rp);
   assign out_data = q_q.mem[q_q.rp[AW-1:0]];

   always_comb begin
      q_d = q_q;
      if (in_valid && in_ready) begin
         q_d.mem[q_q.wp[AW-1:0]] = in_data;
         q_d.wp = q_q.wp + 1'b1;
      end
      if (out_valid && out_ready) begin
         q_d.rp = q_q.rp + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q_q <= '0;
      end else begin
         q_q <= q_d;
      end
   end
endmodule : word_fifo

/* File: logic/sensor_port_dev.sv */
/*
 Device end of the sensor serial port: SPI slave on the link clock, bus condition
 monitor and user-side register write and read ports on the system clock.
 Assumes the host drives select, link clock and data input; the user answers a
 read request within two system clock cycles.
*/
`timescale 1ns/1ns
module sensor_port_dev
   import serial_port_pkg::*;
(
   input logic clk,
   input logic arst_n,
   spi_link_if.dev link,
   output logic wr_valid,
   input logic wr_ready,
   output logic [IDX_W-1:0] wr_index,
   output logic [BYTE_W-1:0] wr_data,
   output logic wr_room,
   output logic rd_req,
   output logic [IDX_W-1:0] rd_index,
   input logic rd_valid,
   input logic [BYTE_W-1:0] rd_data,
   output logic cond_start,
   output logic cond_stop,
   output logic cond_ack,
   output logic cond_nack
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Link side, rising edge of the link clock

   typedef struct packed {
      logic cmd_done;
      logic is_read;
      logic [2:0] bit_cnt;
      logic [IDX_W-1:0] idx;
      logic [BYTE_W-1:0] sh;
      logic [WORD_W-1:0] wr_word;
   } link_s;

   typedef struct packed {
      logic wr;
      logic rd;
   } tgl_s;

   typedef struct packed {
      logic [BYTE_W-1:0] sh;
   } tx_s;

   typedef struct packed {
      logic [1:0] cs;
      logic [2:0] scl;
      logic [2:0] sda;
      logic [2:0] wr;
      logic [2:0] rd;
      logic [BYTE_W-1:0] rd_word;
      logic rd_req;
      logic rd_pend;
      logic [IDX_W-1:0] rd_index;
      logic i2c_busy;
      logic [3:0] i2c_cnt;
      logic start;
      logic stop;
      logic ack;
      logic nack;
   } sys_s;

   link_s lk_q;
   link_s lk_d;
   tx_s tx_q;
   tx_s tx_d;
   tgl_s tg_q;
   tgl_s tg_d;
   sys_s sy_q;
   sys_s sy_d;
   logic lrst_n;
   logic push;
   logic rd_event;
   logic scl_now;
   logic scl_old;
   logic sda_now;
   logic sda_old;
   logic bus_idle;
   logic scl_rise;
   logic [WORD_W-1:0] fifo_out;

   // A frame ends by the select alone; the link clock may stop right after it
   assign lrst_n = arst_n & ~link.cs_n;

   always_comb begin
      lk_d = lk_q;
      tg_d = tg_q;
      lk_d.sh = {lk_q.sh[BYTE_W-2:0], link.sdi};
      lk_d.bit_cnt = lk_q.bit_cnt + 3'h1;
      if (lk_q.bit_cnt == LAST_BIT) begin
         if (!lk_q.cmd_done) begin
            lk_d.cmd_done = 1'b1;
            lk_d.is_read = (lk_d.sh[BYTE_W-1] == READ_FLAG);
            lk_d.idx = lk_d.sh[IDX_W-1:0];
         end else begin
            if (!lk_q.is_read) begin
               lk_d.wr_word = {lk_q.idx, lk_d.sh};
               tg_d.wr = ~tg_q.wr;
            end
            lk_d.idx = lk_q.idx + 7'h01;
         end
         if (lk_d.is_read) begin
            tg_d.rd = ~tg_q.rd;
         end
      end
   end

   always_ff @(posedge link.sclk or negedge lrst_n) begin
      if (!lrst_n) begin
         lk_q <= '0;
      end else begin
         lk_q <= lk_d;
      end
   end

   // Toggles outlive the frame: clearing them at deselect would look like one more word
   always_ff @(posedge link.sclk or negedge arst_n) begin
      if (!arst_n) begin
         tg_q <= '0;
      end else begin
         tg_q <= tg_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Link side, falling edge: read data goes out

   always_comb begin
      tx_d.sh = {tx_q.sh[BYTE_W-2:0], 1'b0};
      // Byte boundary of a read: the fetch of this word began on the rising edge half a link period ago
      if ((lk_q.bit_cnt == 3'h0) && lk_q.cmd_done && lk_q.is_read) begin
         tx_d.sh = sy_q.rd_word;
      end
   end

   always_ff @(negedge link.sclk or negedge lrst_n) begin
      if (!lrst_n) begin
         tx_q <= '0;
      end else begin
         tx_q <= tx_d;
      end
   end

   assign link.sdo_o = tx_q.sh[BYTE_W-1];
   assign link.sdo_oe = ~link.cs_n;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // System side: crossings and bus condition monitor

   assign push = sy_q.wr[2] ^ sy_q.wr[1];
   assign rd_event = sy_q.rd[2] ^ sy_q.rd[1];
   assign scl_now = sy_q.scl[1];
   assign scl_old = sy_q.scl[2];
   assign sda_now = sy_q.sda[1];
   assign sda_old = sy_q.sda[2];
   assign bus_idle = sy_q.cs[1];
   assign scl_rise = scl_now && !scl_old;

   always_comb begin
      sy_d = sy_q;
      sy_d.cs = {sy_q.cs[0], link.cs_n};
      sy_d.scl = {sy_q.scl[1:0], link.sclk};
      sy_d.sda = {sy_q.sda[1:0], link.sdi};
      sy_d.wr = {sy_q.wr[1:0], tg_q.wr};
      sy_d.rd = {sy_q.rd[1:0], tg_q.rd};
      sy_d.rd_req = 1'b0;
      sy_d.start = 1'b0;
      sy_d.stop = 1'b0;
      sy_d.ack = 1'b0;
      sy_d.nack = 1'b0;
      // Index is stable for a whole byte once its toggle has crossed
      if (rd_event) begin
         sy_d.rd_req = 1'b1;
         sy_d.rd_pend = 1'b1;
         sy_d.rd_index = lk_q.idx;
      end else if (sy_q.rd_pend && rd_valid) begin
         sy_d.rd_pend = 1'b0;
         sy_d.rd_word = rd_data;
      end
      // Only watched while deselected, so SPI traffic never looks like a condition
      if (bus_idle && scl_now && scl_old && sda_old && !sda_now) begin
         sy_d.start = 1'b1;
         sy_d.i2c_busy = 1'b1;
         sy_d.i2c_cnt = 4'h0;
      end else if (bus_idle && scl_now && scl_old && !sda_old && sda_now) begin
         sy_d.stop = 1'b1;
         sy_d.i2c_busy = 1'b0;
      end else if (bus_idle && sy_q.i2c_busy && scl_rise) begin
         sy_d.i2c_cnt = sy_q.i2c_cnt + 4'h1;
         if (sy_d.i2c_cnt == ACK_CLOCK) begin
            sy_d.ack = !sda_now;
            sy_d.nack = sda_now;
            sy_d.i2c_cnt = 4'h0;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sy_q <= '0;
      end else begin
         sy_q <= sy_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Write words queue here; a full queue drops the word, so wr_room warns the user

   word_fifo #(
      .W(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_wr_fifo (
      .clk(clk),
      .arst_n(arst_n),
      .in_valid(push),
      .in_ready(wr_room),
      .in_data(lk_q.wr_word),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data(fifo_out)
   );

   assign wr_index = fifo_out[WORD_W-1:BYTE_W];
   assign wr_data = fifo_out[BYTE_W-1:0];
   assign rd_req = sy_q.rd_req;
   assign rd_index = sy_q.rd_index;
   assign cond_start = sy_q.start;
   assign cond_stop = sy_q.stop;
   assign cond_ack = sy_q.ack;
   assign cond_nack = sy_q.nack;

endmodule : sensor_port_dev

/* File: logic/sensor_port_host.sv */
/*
 Host end of the sensor serial port: SPI master with its own divided link clock,
 plus start and stop conditions and single clocked bits while deselected.
 Assumes one device on the link and a user that feeds write bytes on request.
*/
`timescale 1ns/1ns
module sensor_port_host
   import serial_port_pkg::*;
#(
   parameter int SLOW_HALF = HALF_SLOW_CYC,
   parameter int FAST_HALF = HALF_FAST_CYC
) (
   input logic clk,
   input logic arst_n,
   spi_link_if.host link,
   input logic cmd_valid,
   output logic cmd_ready,
   input logic [1:0] cmd_op,
   input logic cmd_read,
   input logic [IDX_W-1:0] cmd_index,
   input logic [4:0] cmd_len,
   input logic tx_valid,
   output logic tx_ready,
   input logic [BYTE_W-1:0] tx_data,
   output logic rx_valid,
   output logic [BYTE_W-1:0] rx_data
);
   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_HI, ST_LO, ST_DONE, ST_C0, ST_C1, ST_C2}
      host_state_e;

   typedef struct packed {
      host_state_e st;
      logic [7:0] cnt;
      logic [7:0] half;
      logic [BYTE_W-1:0] sh;
      logic [2:0] bit_cnt;
      logic first;
      logic cond;
      logic rd;
      logic [4:0] left;
      logic cs_n;
      logic sclk;
      logic sdi;
      logic [1:0] miso;
      logic rx_valid;
      logic [BYTE_W-1:0] rx_data;
   } host_s;

   host_s q_q;
   host_s q_d;
   logic tick;
   logic byte_end;
   logic need_tx;
   logic [BYTE_W-1:0] nxt;

   ////////////////////////////////////////////////////////////////////////////////////////////
   assign tick = (q_q.cnt == q_q.half - 8'h01);
   assign byte_end = (q_q.bit_cnt == LAST_BIT);
   assign need_tx = byte_end && !q_q.rd && ((q_q.left > 5'h1) || q_q.first);
   assign tx_ready = (q_q.st == ST_HI) && tick && need_tx;
   assign cmd_ready = (q_q.st == ST_IDLE);
   assign nxt = {q_q.sh[BYTE_W-2:0], q_q.miso[1]};

   always_comb begin
      q_d = q_q;
      q_d.miso = {q_q.miso[0], link.sdo};
      q_d.rx_valid = 1'b0;
      q_d.cnt = tick ? 8'h00 : q_q.cnt + 8'h01;
      case (q_q.st)
         ST_IDLE: begin
            q_d.cnt = 8'h00;
            q_d.half = 8'(SLOW_HALF);
            if (cmd_valid && cmd_op == OP_XFER) begin
               q_d.cs_n = 1'b0;
               q_d.sh = {cmd_read, cmd_index};
               q_d.sdi = cmd_read;
               q_d.rd = cmd_read;
               q_d.first = 1'b1;
               q_d.bit_cnt = 3'h0;
               q_d.left = (cmd_len == 5'h0) ? 5'h1 : cmd_len;
               if (cmd_read && cmd_index >= SENSOR_FIRST && cmd_index <= SENSOR_LAST) begin
                  q_d.half = 8'(FAST_HALF);
               end
               q_d.st = ST_SETUP;
            end else if (cmd_valid) begin
               q_d.sdi = (cmd_op == OP_START) || ((cmd_op == OP_BIT) && cmd_read);
               q_d.cond = (cmd_op != OP_BIT);
               q_d.st = ST_C0;
            end
         end
         ST_SETUP: if (tick) begin
            q_d.sclk = 1'b1;
            q_d.st = ST_HI;
         end
         ST_HI: if (tick) begin
            if (need_tx && !tx_valid) begin
               q_d.cnt = q_q.cnt; // Clock held high until the user supplies a byte
            end else begin
               q_d.sclk = 1'b0;
               q_d.sh = nxt;
               q_d.bit_cnt = q_q.bit_cnt + 3'h1;
               q_d.st = ST_LO;
               if (byte_end) begin
                  q_d.first = 1'b0;
                  if (!q_q.first) begin
                     q_d.left = q_q.left - 5'h1;
                     q_d.rx_valid = q_q.rd;
                     q_d.rx_data = nxt;
                  end
                  if (need_tx) begin
                     q_d.sh = tx_data;
                  end else if (!q_q.first && q_q.left == 5'h1) begin
                     q_d.st = ST_DONE;
                  end
               end
               q_d.sdi = q_d.sh[BYTE_W-1];
            end
         end
         ST_LO: if (tick) begin
            q_d.sclk = 1'b1;
            q_d.st = ST_HI;
         end
         ST_DONE: if (tick) begin
            q_d.cs_n = 1'b1;
            q_d.st = ST_IDLE;
         end
         ST_C0: if (tick) begin
            q_d.sclk = 1'b1;
            q_d.st = ST_C1;
         end
         ST_C1: if (tick) begin
            // A plain bit keeps its data level through the high phase
            if (q_q.cond) begin
               q_d.sdi = ~q_q.sdi;
            end
            q_d.st = ST_C2;
         end
         ST_C2: if (tick) begin
            q_d.sclk = 1'b0;
            q_d.st = ST_IDLE;
         end
         default: q_d.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q_q <= '{st: ST_IDLE, cs_n: 1'b1, sdi: 1'b1, default: '0};
      end else begin
         q_q <= q_d;
      end
   end

   assign link.cs_n = q_q.cs_n;
   assign link.sclk = q_q.sclk;
   assign link.sdi = q_q.sdi;
   assign rx_valid = q_q.rx_valid;
   assign rx_data = q_q.rx_data;

endmodule : sensor_port_host

/* File: dv/sensor_port_assertions.sv */
/*
 Checker on the link wires between host end and device end.
 Assumes both ends run on clk and the host makes the link clock from it.
*/
`timescale 1ns/1ns
module sensor_port_assertions (
   input logic clk,
   input logic arst_n,
   input logic cs_n,
   input logic sclk,
   input logic sdi,
   input logic sdo_o,
   input logic sdo_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   ////////////////////////////////////////////////////////////////////////////////
   // Rising link edges within the current frame; cleared while deselected
   logic sclk_q;
   logic [9:0] rise_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sclk_q <= 1'h0;
         rise_q <= 10'h000;
      end else begin
         sclk_q <= sclk;
         if (cs_n) rise_q <= 10'h000;
         else if (sclk && !sclk_q) rise_q <= rise_q + 10'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   a_release_idle: assert property (cs_n |-> !sdo_oe)
      else $error("data output driven while deselected");
   a_drive_selected: assert property (!cs_n |-> sdo_oe)
      else $error("data output released while selected");
   a_sdo_on_fall: assert property (!cs_n && !$past(cs_n) && $changed(sdo_o) |-> $fell(sclk))
      else $error("device data changed away from a falling edge");
   a_sdi_stable_high: assert property (!cs_n && !$past(cs_n) && sclk && $past(sclk) |-> $stable(sdi))
      else $error("host data changed while link clock high");
   a_select_edges_low: assert property ($changed(cs_n) |-> !sclk)
      else $error("select moved while link clock high");
   a_first_bit_setup: assert property ($fell(cs_n) |-> !sclk [*8])
      else $error("link clock rose too soon after select");
   a_high_phase_len: assert property (!cs_n && $rose(sclk) |-> sclk [*8])
      else $error("link clock high phase too short");
   a_low_phase_len: assert property (!cs_n && $fell(sclk) |-> !sclk [*8])
      else $error("link clock low phase too short");
   a_frame_whole_bytes: assert property ($rose(cs_n) |-> rise_q >= 10'h010 && rise_q[2:0] == 3'h0)
      else $error("frame not whole bytes of at least two");
   a_start_shape: assert property (cs_n && sclk && $fell(sdi) |-> sclk [*4])
      else $error("start condition without clock high");
   a_stop_shape: assert property (cs_n && sclk && $rose(sdi) |-> sclk [*4])
      else $error("stop condition without clock high");

   c_long_frame: cover property ($rose(cs_n) && rise_q > 10'h010);
   c_start: cover property (cs_n && sclk && $fell(sdi));
   c_stop: cover property (cs_n && sclk && $rose(sdi));
   c_read_data: cover property (!cs_n && $fell(sclk) && $changed(sdo_o));
endmodule : sensor_port_assertions

/* File: dv/tb.sv */
/*
 Self-checking bench: host end and device end joined by the link carrier.
 Assumes one 250 MHz clock for both ends; the host divides it for the link clock.
*/
`timescale 1ns/1ns
module tb;
   import serial_port_pkg::*;
   logic clk = 1'h0;
   logic arst_n = 1'h0;
   logic cmd_valid = 1'h0;
   logic [1:0] cmd_op = 2'h0;
   logic cmd_read = 1'h0;
   logic [IDX_W-1:0] cmd_index = 7'h00;
   logic [4:0] cmd_len = 5'h00;
   logic tx_valid = 1'h0;
   logic [7:0] tx_pos = 8'h00;
   logic [7:0] p0 = 8'h00;
   logic wr_ready = 1'h0;
   logic rd_valid = 1'h0;
   logic [BYTE_W-1:0] rd_data = 8'h00;
   logic cmd_ready, tx_ready, rx_valid, wr_valid, wr_room, rd_req;
   logic c_start, c_stop, c_ack, c_nack;
   logic [BYTE_W-1:0] rx_data, wr_data;
   logic [IDX_W-1:0] wr_index, rd_index;
   logic [7:0] sh = 8'h00;
   int nb = 0;
   int n_start = 0;
   int n_stop = 0;
   int n_ack = 0;
   int n_nack = 0;
   int num_errors = 0;
   int cmp_count = 0;
   logic [14:0] wq[$];
   logic [7:0] rq[$];

   function automatic logic [7:0] tpat(input logic [7:0] p);
      return p ^ 8'h6c;
   endfunction : tpat
   function automatic logic [7:0] rpat(input logic [6:0] i);
      return {1'h0, i} ^ 8'ha5;
   endfunction : rpat

   always #2 clk = ~clk;

   spi_link_if link ();
   sensor_port_host #(.SLOW_HALF(12), .FAST_HALF(8)) sensor_port_host_i (
      .clk(clk), .arst_n(arst_n), .link(link.host), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_read(cmd_read), .cmd_index(cmd_index),
      .cmd_len(cmd_len), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tpat(tx_pos)),
      .rx_valid(rx_valid), .rx_data(rx_data));
   sensor_port_dev sensor_port_dev_i (
      .clk(clk), .arst_n(arst_n), .link(link.dev), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .wr_index(wr_index), .wr_data(wr_data), .wr_room(wr_room), .rd_req(rd_req),
      .rd_index(rd_index), .rd_valid(rd_valid), .rd_data(rd_data), .cond_start(c_start),
      .cond_stop(c_stop), .cond_ack(c_ack), .cond_nack(c_nack));
   sensor_port_assertions sensor_port_assertions_i (
      .clk(clk), .arst_n(arst_n), .cs_n(link.cs_n), .sclk(link.sclk), .sdi(link.sdi),
      .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe));

   ////////////////////////////////////////////////////////////////////////////////
   // User sides: write sink, read source answering next cycle, receive and event logs
   always @(posedge clk) begin
      if (tx_ready === 1'h1 && tx_valid === 1'h1) tx_pos <= #1 tx_pos + 8'h01;
      rd_valid <= #1 (rd_req === 1'h1);
      rd_data <= #1 rpat(rd_index);
      if (wr_valid === 1'h1 && wr_ready === 1'h1) wq.push_back({wr_index, wr_data});
      if (rx_valid === 1'h1) rq.push_back(rx_data);
      if (c_start === 1'h1) n_start++;
      if (c_stop === 1'h1) n_stop++;
      if (c_ack === 1'h1) n_ack++;
      if (c_nack === 1'h1) n_nack++;
   end

   // Wire sniffer: samples the host data on rising link edges inside a frame
   always @(negedge link.cs_n) nb = 0;
   always @(posedge link.sclk) begin
      if (link.cs_n === 1'h0) begin
         if (nb < 8) sh = {sh[6:0], link.sdi};
         nb++;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask : chk

   task automatic run(input logic [1:0] op, input logic rd, input logic [6:0] idx,
                      input logic [4:0] len);
      int t;
      @(posedge clk);
      #1;
      cmd_op = op;
      cmd_read = rd;
      cmd_index = idx;
      cmd_len = len;
      cmd_valid = 1'h1;
      t = 0;
      // Ready is looked at where it has settled; the edge after that takes the command
      while (cmd_ready !== 1'h1 && t < 100) begin
         @(posedge clk);
         #1;
         t++;
      end
      @(posedge clk);
      #1;
      cmd_valid = 1'h0;
      t = 0;
      do begin @(posedge clk); #1; t++; end while (cmd_ready !== 1'h1 && t < 20000);
      chk("command finished", 1, t < 20000);
   endtask : run

   task automatic xfer(input logic rd, input logic [6:0] idx, input logic [4:0] len);
      p0 = tx_pos;
      run(OP_XFER, rd, idx, len);
      repeat (4) @(posedge clk);
      #1;
      chk("command byte", {rd, idx}, sh);
      chk("frame clocks", 8 * (len + 1), nb);
      chk("idle select", 1, link.cs_n);
      chk("released data line", 0, link.sdo_oe);
   endtask : xfer

   task automatic exp_wr(input logic [6:0] idx, input int n);
      logic [6:0] ix;
      chk("write count", n, wq.size());
      for (int i = 0; i < n && wq.size() > 0; i++) begin
         ix = idx + i[6:0];
         chk("write word", {ix, tpat(p0 + i[7:0])}, wq.pop_front());
      end
   endtask : exp_wr

   task automatic exp_rd(input logic [6:0] idx, input int n);
      chk("read count", n, rq.size());
      for (int i = 0; i < n && rq.size() > 0; i++) begin
         chk("read byte", rpat(idx + i[6:0]), rq.pop_front());
      end
   endtask : exp_rd

   task automatic test_done();
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk);
      #1;
      arst_n = 1'h1;
      tx_valid = 1'h1;
      wr_ready = 1'h1;
      xfer(1'h0, 7'h05, 5'd1);
      exp_wr(7'h05, 1);
      // Burst across the top of the index space wraps to zero
      xfer(1'h0, 7'h7e, 5'd3);
      exp_wr(7'h7e, 3);
      xfer(1'h1, 7'h20, 5'd1);
      exp_rd(7'h20, 1);
      // Sensor range runs the faster link clock
      xfer(1'h1, 7'h12, 5'd4);
      exp_rd(7'h12, 4);
      // Stalled sink: sixteen words kept, the surplus four dropped
      wr_ready = 1'h0;
      xfer(1'h0, 7'h30, 5'd20);
      chk("room when full", 0, wr_room);
      chk("words waiting", 1, wr_valid);
      wr_ready = 1'h1;
      repeat (40) @(posedge clk);
      exp_wr(7'h30, 16);
      run(OP_START, 1'h0, 7'h00, 5'd0);
      repeat (8) @(posedge clk);
      chk("start events", 1, n_start);
      // Two bytes of ones; the ninth clock of the first is low, of the second high
      for (int i = 0; i < 18; i++) begin
         run(OP_BIT, i != 8, 7'h00, 5'd0);
      end
      run(OP_STOP, 1'h0, 7'h00, 5'd0);
      repeat (8) @(posedge clk);
      chk("stop events", 1, n_stop);
      chk("ack events", 1, n_ack);
      chk("nack events", 1, n_nack);
      test_done();
   end

   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      $display("watchdog expired");
      test_done();
   end
endmodule : tb
